// *** design/system_reset_controller.sv ***
`timescale 1ns/10ps
`include "reset_ctrl_params.svh"
// Summary of operation
// - regulator below range produces a system reset; supply alarms interrupt unless set to reset
// - system reset returns processor, peripherals and registers to reset state
// - power-on reset lasts at least 150 ns, longer while supplies ramp
// - after boot power-on monitor turns off; precise monitor takes over
// - precise trip, pin and software reset act like power-on reset but keep status and watchdog enable
// - digital precise monitor cannot be disabled; analog part follows regulator enable
// - precise monitor off in sleep and hibernate, briefly on during buzz
// - high alarm fixed 5.75 V; low alarms programmable in 250 mV steps
// - each low alarm can reset instead of interrupting
// - alarms disabled until power-on reset done; in sleep only on buzz
// - alarm in sleep buzz runs wakeup first, then interrupt recognized
// - reset held while pin low, also honoured in sleep and hibernate
// - writing software reset bit triggers reset, from processor or dma
// - separate control bit blocks software reset
// - watchdog resets if not cleared within selected timeout
// - power-on disables watchdog; enable sticks until next power-on reset
// - status register records causes and alarms; cleared by power-on reset
module system_reset_controller
   import reset_ctrl_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic por_trip_i,
   input wire logic supply_ramping_i,
   input wire logic dig_reg_low_i,
   input wire logic ana_reg_low_i,
   input wire logic ana_supply_low_i,
   input wire logic dig_supply_low_i,
   input wire logic ana_supply_high_i,
   input wire logic ext_reset_pin_n_i,
   input wire logic [1:0] power_mode_i,
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   output logic sys_reset_n_o,
   output logic por_monitor_en_o,
   output logic precise_dig_en_o,
   output logic precise_ana_en_o,
   output logic alarm_mon_en_o,
   output logic [3:0] ana_low_level_o,
   output logic [3:0] dig_low_level_o,
   output logic buzz_o,
   output logic wakeup_req_o,
   output logic alarm_irq_o
);
   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   localparam int NSYNC = 8;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] sync1_reg;
   logic [NSYNC-1:0] sync_reg;
   assign raw_in = {ana_supply_high_i, dig_supply_low_i, ana_supply_low_i, ana_reg_low_i,
                    dig_reg_low_i, supply_ramping_i, ~ext_reset_pin_n_i, por_trip_i};
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge mclk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               sync1_reg[gi] <= 1'b0;
               sync_reg[gi] <= 1'b0;
            end else begin
               sync1_reg[gi] <= raw_in[gi];
               sync_reg[gi] <= sync1_reg[gi];
            end
         end
      end
   endgenerate
   logic por_s, ramp_s, pin_s, dreg_s, areg_s, alow_s, dlow_s, ahigh_s;
   assign {ahigh_s, dlow_s, alow_s, areg_s, dreg_s, ramp_s, pin_s, por_s} = sync_reg;

   // ----------------------------------------------------------------
   // power-on stage: true cold reset, kept apart from the system reset
   // ----------------------------------------------------------------
   logic por_hold;
   logic boot_done_reg;
   seq_state_t seq_reg;
   // the trip pin itself is synchronised first; stretched for ramping supplies
   reset_stretch u_por_stretch (
      .mclk_i(mclk_i),
      .arst_n_i(rst_n_i),
      .req_i(por_s | ramp_s),
      .hold_o(por_hold)
   );
   // boot sequence: once power-on pulse ends, hand over to precise monitor
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         seq_reg <= SEQ_BOOT;
         boot_done_reg <= 1'b0;
      end else begin
         case (seq_reg)
            SEQ_BOOT: begin
               if (!por_hold) begin
                  seq_reg <= SEQ_RUN;
                  boot_done_reg <= 1'b1;
               end
            end
            SEQ_RUN: begin
               if (por_hold) begin
                  seq_reg <= SEQ_BOOT;
                  boot_done_reg <= 1'b0;
               end
            end
            default: seq_reg <= SEQ_BOOT;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // registers that survive system reset (cleared only by power-on)
   // ----------------------------------------------------------------
   logic wdog_en_reg;
   logic [15:0] status_reg;
   logic [15:0] status_next;
   logic sys_rst_active; // raw combined request, pulse level
   logic precise_low_voltage_reset_trip, alow_rst, dlow_rst, wdog_fire, sw_fire;
   logic alow_irq, dlow_irq, ahigh_irq;
   logic por_n;
   assign por_n = rst_n_i & ~por_hold;
   logic wr_status;
   assign wr_status = wr_i && addr_i == `ADDR_STATUS;

   // watchdog enable is write-once-set
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wdog_en_reg <= 1'b0;
      end else if (por_hold) begin
         wdog_en_reg <= 1'b0;
      end else if (wr_i && addr_i == `ADDR_CTRL && wdata_i[`CTRL_WDOG_EN_BIT]) begin
         wdog_en_reg <= 1'b1;
      end
   end

   // status: events set, write-one clears; set wins over clear
   always_comb begin
      status_next = status_reg;
      if (wr_status) begin
         status_next = status_reg & ~wdata_i;
      end
      status_next[`ST_PRECISE_LOW_VOLTAGE_RESET_BIT] = status_next[`ST_PRECISE_LOW_VOLTAGE_RESET_BIT] | precise_low_voltage_reset_trip;
      status_next[`ST_PIN_BIT] = status_next[`ST_PIN_BIT] | pin_s;
      status_next[`ST_SW_BIT] = status_next[`ST_SW_BIT] | sw_fire;
      status_next[`ST_WDOG_BIT] = status_next[`ST_WDOG_BIT] | wdog_fire;
      status_next[`ST_ALOW_BIT] = status_next[`ST_ALOW_BIT] | alow_irq;
      status_next[`ST_DLOW_BIT] = status_next[`ST_DLOW_BIT] | dlow_irq;
      status_next[`ST_AHIGH_BIT] = status_next[`ST_AHIGH_BIT] | ahigh_irq;
      status_next[`ST_ALOW_RST_BIT] = status_next[`ST_ALOW_RST_BIT] | alow_rst;
      status_next[`ST_DLOW_RST_BIT] = status_next[`ST_DLOW_RST_BIT] | dlow_rst;
   end
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         status_reg <= `ST_RST;
      end else if (por_hold) begin
         status_reg <= `ST_RST;
      end else begin
         status_reg <= status_next;
      end
   end

   // ----------------------------------------------------------------
   // combined system reset
   // ----------------------------------------------------------------
   logic sys_sync1_reg;
   logic sys_sync_reg;
   logic sys_n;
   // sources pass one flop before the async reset: status records the cause at the same
   // edge, before the reset clears the register that raised it, and no glitch gets through
   logic rst_req_reg;
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_req_reg <= 1'b0;
      end else begin
         rst_req_reg <= sys_rst_active;
      end
   end
   // async assert from any request, two-stage synchronous release
   assign sys_n = por_n & ~rst_req_reg;
   always_ff @(posedge mclk_i or negedge sys_n) begin
      if (!sys_n) begin
         sys_sync1_reg <= 1'b0;
         sys_sync_reg <= 1'b0;
      end else begin
         sys_sync1_reg <= 1'b1;
         sys_sync_reg <= sys_sync1_reg;
      end
   end
   // the output flop is the release stage itself
   assign sys_reset_n_o = sys_sync_reg;
   logic srst_n;
   assign srst_n = sys_sync_reg;

   // ----------------------------------------------------------------
   // firmware registers, cleared by system reset
   // ----------------------------------------------------------------
   logic sw_block_reg, areg_en_reg;
   logic [15:0] cfg_reg, wdog_to_reg, buzz_per_reg, wdog_cnt_reg, buzz_cnt_reg;
   logic sw_req_reg;
   always_ff @(posedge mclk_i or negedge srst_n) begin
      if (!srst_n) begin
         sw_block_reg <= 1'(`CTRL_RST >> `CTRL_SWRST_BLOCK_BIT);
         areg_en_reg <= 1'(`CTRL_RST >> `CTRL_AREG_EN_BIT);
         cfg_reg <= `CFG_RST;
         wdog_to_reg <= `WDOG_TIMEOUT_RST;
         buzz_per_reg <= `BUZZ_PERIOD_RST;
         sw_req_reg <= 1'b0;
      end else begin
         sw_req_reg <= 1'b0;
         if (wr_i && addr_i == `ADDR_CTRL) begin
            sw_block_reg <= wdata_i[`CTRL_SWRST_BLOCK_BIT];
            areg_en_reg <= wdata_i[`CTRL_AREG_EN_BIT];
            sw_req_reg <= wdata_i[`CTRL_SWRST_BIT];
         end
         if (wr_i && addr_i == `ADDR_ALARM_CFG) cfg_reg <= wdata_i;
         if (wr_i && addr_i == `ADDR_WDOG_TIMEOUT) wdog_to_reg <= wdata_i;
         if (wr_i && addr_i == `ADDR_BUZZ_PERIOD) buzz_per_reg <= wdata_i;
      end
   end
   assign sw_fire = sw_req_reg & ~sw_block_reg;

   // watchdog counter, cleared by firmware kick
   always_ff @(posedge mclk_i or negedge srst_n) begin
      if (!srst_n) begin
         wdog_cnt_reg <= 16'h0000;
      end else if (!wdog_en_reg ||
                   (wr_i && addr_i == `ADDR_CTRL && wdata_i[`CTRL_WDOG_CLEAR_BIT])) begin
         wdog_cnt_reg <= 16'h0000;
      end else if (wdog_cnt_reg != wdog_to_reg) begin
         wdog_cnt_reg <= wdog_cnt_reg + 16'h0001;
      end
   end
   assign wdog_fire = wdog_en_reg && wdog_cnt_reg == wdog_to_reg;

   // buzz schedule in sleep: short window every period
   logic sleep_m, hib_m, buzz_reg;
   assign sleep_m = power_mode_i == MODE_SLEEP;
   assign hib_m = power_mode_i == MODE_HIBERNATE;
   always_ff @(posedge mclk_i or negedge srst_n) begin
      if (!srst_n) begin
         buzz_cnt_reg <= 16'h0000;
         buzz_reg <= 1'b0;
      end else if (!sleep_m) begin
         buzz_cnt_reg <= 16'h0000;
         buzz_reg <= 1'b0;
      end else begin
         buzz_cnt_reg <= (buzz_cnt_reg >= buzz_per_reg) ? 16'h0000 : buzz_cnt_reg + 16'h0001;
         buzz_reg <= buzz_cnt_reg < `BUZZ_WIDTH;
      end
   end

   // monitor enables: precise digital always on when awake
   logic pdig_en, pana_en, alarm_en;
   assign pdig_en = boot_done_reg & ((!sleep_m && !hib_m) | (sleep_m & buzz_reg));
   assign pana_en = pdig_en & areg_en_reg;
   assign alarm_en = boot_done_reg & (!hib_m) & (!sleep_m | buzz_reg);
   assign precise_low_voltage_reset_trip = (pdig_en & dreg_s) | (pana_en & areg_s);

   // alarm routing: reset instead of interrupt when selected
   logic alow_hit, dlow_hit;
   assign alow_hit = alarm_en & cfg_reg[`CFG_ALOW_EN_BIT] & alow_s;
   assign dlow_hit = alarm_en & cfg_reg[`CFG_DLOW_EN_BIT] & dlow_s;
   assign alow_rst = alow_hit & cfg_reg[`CFG_ALOW_RST_BIT];
   assign dlow_rst = dlow_hit & cfg_reg[`CFG_DLOW_RST_BIT];
   assign alow_irq = alow_hit & ~cfg_reg[`CFG_ALOW_RST_BIT];
   assign dlow_irq = dlow_hit & ~cfg_reg[`CFG_DLOW_RST_BIT];
   assign ahigh_irq = alarm_en & cfg_reg[`CFG_AHIGH_EN_BIT] & ahigh_s;
   assign sys_rst_active = pin_s | precise_low_voltage_reset_trip | sw_fire | wdog_fire | alow_rst | dlow_rst;

   // ----------------------------------------------------------------
   // wakeup then interrupt, and outputs
   // ----------------------------------------------------------------
   logic any_irq, pend_reg, irq_reg, wake_reg;
   assign any_irq = alow_irq | dlow_irq | ahigh_irq;
   // in sleep the interrupt waits until the mode has left sleep
   always_ff @(posedge mclk_i or negedge srst_n) begin
      if (!srst_n) begin
         pend_reg <= 1'b0;
         irq_reg <= 1'b0;
         wake_reg <= 1'b0;
      end else begin
         wake_reg <= sleep_m & (any_irq | pend_reg);
         pend_reg <= sleep_m & (any_irq | pend_reg);
         irq_reg <= !sleep_m & (any_irq | pend_reg);
      end
   end
   assign wakeup_req_o = wake_reg;
   assign alarm_irq_o = irq_reg;
   assign buzz_o = buzz_reg;

   // flopped monitor controls
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         por_monitor_en_o <= 1'b1;
         precise_dig_en_o <= 1'b0;
         precise_ana_en_o <= 1'b0;
         alarm_mon_en_o <= 1'b0;
         ana_low_level_o <= 4'h0;
         dig_low_level_o <= 4'h0;
      end else begin
         por_monitor_en_o <= !boot_done_reg;
         precise_dig_en_o <= pdig_en;
         precise_ana_en_o <= pana_en;
         alarm_mon_en_o <= alarm_en;
         ana_low_level_o <= cfg_reg[`CFG_ALOW_LSB +: 4];
         dig_low_level_o <= cfg_reg[`CFG_DLOW_LSB +: 4];
      end
   end

   // read port, data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 16'h0000;
      end else if (rd_i) begin
         case (addr_i)
            `ADDR_CTRL: rdata_o <= {11'h000, areg_en_reg, 1'b0, wdog_en_reg, sw_block_reg, 1'b0};
            `ADDR_ALARM_CFG: rdata_o <= cfg_reg;
            `ADDR_WDOG_TIMEOUT: rdata_o <= wdog_to_reg;
            `ADDR_STATUS: rdata_o <= status_reg;
            `ADDR_BUZZ_PERIOD: rdata_o <= buzz_per_reg;
            default: rdata_o <= 16'h0000;
         endcase
      end else begin
         rdata_o <= 16'h0000;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence pin_low_s;
      pin_s;
   endsequence
   sequence held_s;
      !sys_reset_n_o;
   endsequence
   pin_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      pin_low_s |=> held_s) else $error("pin reset did not hold system reset");
   sw_block_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      sw_block_reg |-> !sw_fire) else $error("blocked software reset fired");
   wdog_sticky_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      wdog_en_reg && !por_hold |=> wdog_en_reg) else $error("watchdog enable cleared");
   por_off_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      boot_done_reg |=> !por_monitor_en_o) else $error("power-on monitor still on");
   alarm_boot_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      !boot_done_reg |=> !alarm_mon_en_o) else $error("alarms active before boot");
   hib_precise_low_voltage_reset_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      hib_m |=> !precise_dig_en_o) else $error("precise monitor on in hibernate");
   ana_follow_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      precise_ana_en_o |-> $past(areg_en_reg)) else $error("analog monitor without regulator");
   sleep_irq_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      alarm_irq_o |-> $past(!sleep_m)) else $error("interrupt raised while asleep");
   release_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      $rose(sys_reset_n_o) |-> $past(sys_n, 2)) else $error("release not synchronous");
   por_width_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      $fell(por_hold) |-> $past(por_hold, `POR_PULSE_CYC)) else $error("power-on pulse too short");
   status_por_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      por_hold |=> status_reg == `ST_RST) else $error("status not cleared by power-on");
endmodule : system_reset_controller

// *** shared/reset_ctrl_params.svh ***
`ifndef RESET_CTRL_PARAMS_SVH
`define RESET_CTRL_PARAMS_SVH
// register addresses (4-bit index space)
`define ADDR_CTRL 4'h0
`define ADDR_ALARM_CFG 4'h1
`define ADDR_WDOG_TIMEOUT 4'h2
`define ADDR_STATUS 4'h3
`define ADDR_BUZZ_PERIOD 4'h4
// control register bits
`define CTRL_SWRST_BIT 0
`define CTRL_SWRST_BLOCK_BIT 1
`define CTRL_WDOG_EN_BIT 2
`define CTRL_WDOG_CLEAR_BIT 3
`define CTRL_AREG_EN_BIT 4
// alarm config fields
`define CFG_ALOW_LSB 0
`define CFG_DLOW_LSB 4
`define CFG_ALOW_RST_BIT 8
`define CFG_DLOW_RST_BIT 9
`define CFG_ALOW_EN_BIT 10
`define CFG_DLOW_EN_BIT 11
`define CFG_AHIGH_EN_BIT 12
// status bits
`define ST_POR_BIT 0
`define ST_PRECISE_LOW_VOLTAGE_RESET_BIT 1
`define ST_PIN_BIT 2
`define ST_SW_BIT 3
`define ST_WDOG_BIT 4
`define ST_ALOW_BIT 5
`define ST_DLOW_BIT 6
`define ST_AHIGH_BIT 7
`define ST_ALOW_RST_BIT 8
`define ST_DLOW_RST_BIT 9
`define ST_RST 16'h0001
// reset values
`define CTRL_RST 16'h0010
`define CFG_RST 16'h0000
`define WDOG_TIMEOUT_RST 16'hFFFF
`define BUZZ_PERIOD_RST 16'h0100
`define BUZZ_WIDTH 16'h0004
// timing: 150 ns least reset pulse at 5 ns clock
`define CLK_PERIOD_NS 5
`define POR_PULSE_NS 150
`define POR_PULSE_CYC ((`POR_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STRETCH_W 6
`endif

// *** shared/reset_ctrl_pkg.sv ***
package reset_ctrl_pkg;
   // power modes seen by the controller
   typedef enum logic [1:0] {
      MODE_ACTIVE,
      MODE_SLEEP,
      MODE_HIBERNATE
   } power_mode_t;
   // sequencer states for the power-on boot sequence
   typedef enum logic [1:0] {
      SEQ_BOOT,
      SEQ_RUN
   } seq_state_t;
   typedef logic [15:0] reg_word_t;
endpackage : reset_ctrl_pkg

// *** design/reset_stretch.sv ***
`timescale 1ns/10ps
`include "reset_ctrl_params.svh"
// holds its output for a least count after the request falls; released on clock
module reset_stretch (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic req_i,
   output logic hold_o
);
   logic [`STRETCH_W-1:0] cnt_reg;
   // entered on the clock after a request (asynchronously only on arst_n_i), counted out synchronously
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_reg <= `STRETCH_W'(`POR_PULSE_CYC);
         hold_o <= 1'b1;
      end else if (req_i) begin
         cnt_reg <= `STRETCH_W'(`POR_PULSE_CYC);
         hold_o <= 1'b1;
      end else if (cnt_reg != '0) begin
         cnt_reg <= cnt_reg - `STRETCH_W'(1);
         hold_o <= 1'b1;
      end else begin
         hold_o <= 1'b0;
      end
   end
endmodule : reset_stretch

// *** test/board_model.sv ***
`timescale 1ns/10ps
// ------------------------------
// board side: supply ramp and reset pin driver
// ------------------------------
module board_model #(
   parameter int RAMP_CYC = 60,
   parameter int PIN_GAP_CYC = 2000
) (
   input wire logic mclk_i,
   input wire logic pin_req_i,
   output logic ext_reset_pin_n_o,
   output logic supply_ramping_o
);
   int ramp;
   int gap;
   initial begin
      supply_ramping_o = 1'b1;
      ext_reset_pin_n_o = 1'b1;
      ramp = 0;
      gap = PIN_GAP_CYC;
   end
   // slow ramp at power up holds supplies below trip for a while
   always @(posedge mclk_i) begin
      if (ramp < RAMP_CYC) ramp <= ramp + 1;
      else supply_ramping_o <= 1'b0;
   end
   // pin has a pull-up, so released means high; a new low waits out the gap
   always @(posedge mclk_i) begin
      if (pin_req_i && gap >= PIN_GAP_CYC) ext_reset_pin_n_o <= 1'b0;
      else if (!pin_req_i) ext_reset_pin_n_o <= 1'b1;
      if (!ext_reset_pin_n_o) gap <= 0;
      else if (gap < PIN_GAP_CYC) gap <= gap + 1;
   end
endmodule : board_model

// *** test/tb_top.sv ***
`timescale 1ns/10ps
`include "reset_ctrl_params.svh"
module tb_top;
   import reset_ctrl_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic por_trip_i = 1'b0;
   logic supply_ramping_i, ext_reset_pin_n_i, pin_req = 1'b0;
   logic dig_reg_low_i = 1'b0, ana_reg_low_i = 1'b0, ana_supply_low_i = 1'b0;
   logic dig_supply_low_i = 1'b0, ana_supply_high_i = 1'b0;
   logic [1:0] power_mode_i = 2'h0;
   logic [3:0] addr_i = 4'h0;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0, rd_i = 1'b0;
   logic [15:0] rdata_o, v;
   logic sys_reset_n_o, por_monitor_en_o, precise_dig_en_o, precise_ana_en_o;
   logic alarm_mon_en_o, buzz_o, wakeup_req_o, alarm_irq_o;
   logic [3:0] ana_low_level_o, dig_low_level_o;
   int n_fail = 0, n_tests = 0, c;
   // 200 MHz
   always #2.5 mclk_i = ~mclk_i;
   board_model bm (.mclk_i, .pin_req_i(pin_req), .ext_reset_pin_n_o(ext_reset_pin_n_i),
      .supply_ramping_o(supply_ramping_i));
   system_reset_controller dut (.mclk_i, .rst_n_i, .por_trip_i, .supply_ramping_i,
      .dig_reg_low_i, .ana_reg_low_i, .ana_supply_low_i, .dig_supply_low_i,
      .ana_supply_high_i, .ext_reset_pin_n_i, .power_mode_i, .addr_i, .wdata_i, .wr_i,
      .rd_i, .rdata_o, .sys_reset_n_o, .por_monitor_en_o, .precise_dig_en_o,
      .precise_ana_en_o, .alarm_mon_en_o, .ana_low_level_o, .dig_low_level_o, .buzz_o,
      .wakeup_req_o, .alarm_irq_o);
   // ------------------------------
   // helpers
   // ------------------------------
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask : rd
   task automatic rchk(input string nm, input logic [3:0] a, input logic [15:0] e);
      rd(a, v);
      chk(nm, e, v);
   endtask : rchk
   // bounded waits on the combined reset; c returns cycles spent
   task automatic wait_rel();
      c = 0;
      while (sys_reset_n_o !== 1'b1 && c < 500) begin
         @(posedge mclk_i);
         c++;
      end
      chk("release", 16'h1, {15'h0, sys_reset_n_o});
      repeat (2) @(posedge mclk_i);
   endtask : wait_rel
   task automatic wait_low(input int n);
      c = 0;
      while (sys_reset_n_o !== 1'b0 && c < n) begin
         @(posedge mclk_i);
         c++;
      end
      chk("sys_reset_n_o", 16'h0, {15'h0, sys_reset_n_o});
   endtask : wait_low
   task automatic step(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask : step
   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic t_boot();
      chk("por_en", 16'h1, {15'h0, por_monitor_en_o});
      wait_rel();
      chk("stretch", 16'h1, {15'h0, c >= 60});
      chk("por_off", 16'h0, {15'h0, por_monitor_en_o});
      chk("dig_en", 16'h1, {15'h0, precise_dig_en_o});
      chk("ana_en", 16'h1, {15'h0, precise_ana_en_o});
      rchk("status", `ADDR_STATUS, 16'h0001);
      rchk("ctrl", `ADDR_CTRL, `CTRL_RST);
      rchk("cfg", `ADDR_ALARM_CFG, `CFG_RST);
      rchk("wdog", `ADDR_WDOG_TIMEOUT, `WDOG_TIMEOUT_RST);
      rchk("buzz", `ADDR_BUZZ_PERIOD, `BUZZ_PERIOD_RST);
      rchk("unmapped", 4'hA, 16'h0000);
      wr(`ADDR_STATUS, 16'hFFFF);
      $display("boot done");
   endtask : t_boot
   task automatic t_precise();
      wr(`ADDR_CTRL, 16'h0000);
      ana_reg_low_i <= 1'b1;
      step(20);
      chk("ana_en", 16'h0, {15'h0, precise_ana_en_o});
      chk("dig_en", 16'h1, {15'h0, precise_dig_en_o});
      chk("no_rst", 16'h1, {15'h0, sys_reset_n_o});
      @(posedge mclk_i);
      ana_reg_low_i <= 1'b0;
      wr(`ADDR_CTRL, 16'h0010);
      dig_reg_low_i <= 1'b1;
      wait_low(10);
      dig_reg_low_i <= 1'b0;
      wait_rel();
      rchk("status", `ADDR_STATUS, 16'h0002);
      wr(`ADDR_STATUS, 16'hFFFF);
      $display("precise done");
   endtask : t_precise
   task automatic t_soft();
      wr(`ADDR_ALARM_CFG, 16'h0505);
      wr(`ADDR_CTRL, 16'h0013);
      step(20);
      chk("blocked", 16'h1, {15'h0, sys_reset_n_o});
      wr(`ADDR_CTRL, 16'h0011);
      wait_low(5);
      wait_rel();
      rchk("cfg", `ADDR_ALARM_CFG, `CFG_RST);
      rchk("status", `ADDR_STATUS, 16'h0008);
      wr(`ADDR_STATUS, 16'hFFFF);
      $display("soft done");
   endtask : t_soft
   task automatic t_alarm();
      wr(`ADDR_ALARM_CFG, 16'h0505);
      step(2);
      chk("alow_lvl", 16'h5, {12'h0, ana_low_level_o});
      chk("mon_en", 16'h1, {15'h0, alarm_mon_en_o});
      @(posedge mclk_i);
      ana_supply_low_i <= 1'b1;
      wait_low(20);
      ana_supply_low_i <= 1'b0;
      wait_rel();
      rd(`ADDR_STATUS, v);
      chk("st_arst", 16'h0100, v & 16'h011F);
      wr(`ADDR_STATUS, 16'hFFFF);
      wr(`ADDR_ALARM_CFG, 16'h0830);
      dig_supply_low_i <= 1'b1;
      step(10);
      chk("dlow_lvl", 16'h3, {12'h0, dig_low_level_o});
      chk("irq", 16'h1, {15'h0, alarm_irq_o});
      chk("no_rst", 16'h1, {15'h0, sys_reset_n_o});
      // let the synchronised alarm die away, or set-wins keeps its status bit
      @(posedge mclk_i);
      dig_supply_low_i <= 1'b0;
      step(4);
      wr(`ADDR_STATUS, 16'hFFFF);
      $display("alarm done");
   endtask : t_alarm
   task automatic t_sleep();
      wr(`ADDR_BUZZ_PERIOD, 16'h0040);
      wr(`ADDR_ALARM_CFG, 16'h1000);
      power_mode_i <= 2'h1;
      c = 0;
      while (buzz_o !== 1'b1 && c < 200) begin
         @(posedge mclk_i);
         c++;
      end
      chk("buzz_o", 16'h1, {15'h0, buzz_o});
      step(1);
      chk("buzz_dig", 16'h1, {15'h0, precise_dig_en_o});
      chk("buzz_mon", 16'h1, {15'h0, alarm_mon_en_o});
      step(8);
      chk("idle_dig", 16'h0, {15'h0, precise_dig_en_o});
      chk("idle_mon", 16'h0, {15'h0, alarm_mon_en_o});
      @(posedge mclk_i);
      ana_supply_high_i <= 1'b1;
      c = 0;
      while (wakeup_req_o !== 1'b1 && c < 200) begin
         @(posedge mclk_i);
         c++;
      end
      #1 chk("irq_late", 16'h0, {15'h0, alarm_irq_o});
      chk("wake", 16'h1, {15'h0, wakeup_req_o});
      step(20);
      chk("still_asleep", 16'h0, {15'h0, alarm_irq_o});
      // wakeup sequence done: mode back to active, only then the interrupt shows
      @(posedge mclk_i);
      power_mode_i <= 2'h0;
      step(3);
      chk("irq", 16'h1, {15'h0, alarm_irq_o});
      @(posedge mclk_i);
      ana_supply_high_i <= 1'b0;
      step(4);
      wr(`ADDR_STATUS, 16'hFFFF);
      $display("sleep done");
   endtask : t_sleep
   task automatic t_pin();
      power_mode_i <= 2'h2;
      step(5);
      chk("hib_dig", 16'h0, {15'h0, precise_dig_en_o});
      pin_req <= 1'b1;
      wait_low(10);
      step(100);
      chk("held", 16'h0, {15'h0, sys_reset_n_o});
      pin_req <= 1'b0;
      wait_rel();
      power_mode_i <= 2'h0;
      rchk("status", `ADDR_STATUS, 16'h0004);
      wr(`ADDR_STATUS, 16'hFFFF);
      $display("pin done");
   endtask : t_pin
   task automatic t_wdog();
      wr(`ADDR_WDOG_TIMEOUT, 16'h0028);
      wr(`ADDR_CTRL, 16'h0014);
      repeat (4) begin
         step(20);
         wr(`ADDR_CTRL, 16'h0018);
         chk("kicked", 16'h1, {15'h0, sys_reset_n_o});
      end
      wr(`ADDR_CTRL, 16'h0010);
      rchk("sticky", `ADDR_CTRL, 16'h0014);
      wait_low(80);
      wait_rel();
      rchk("status", `ADDR_STATUS, 16'h0010);
      rchk("en_kept", `ADDR_CTRL, 16'h0014);
      @(posedge mclk_i);
      rst_n_i <= 1'b0;
      step(3);
      @(posedge mclk_i);
      rst_n_i <= 1'b1;
      wait_rel();
      rchk("en_off", `ADDR_CTRL, `CTRL_RST);
      rchk("st_clr", `ADDR_STATUS, 16'h0001);
      $display("wdog done");
   endtask : t_wdog
   // ------------------------------
   // run control
   // ------------------------------
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   initial begin
      repeat (3) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      t_boot();
      t_precise();
      t_soft();
      t_alarm();
      t_sleep();
      t_pin();
      t_wdog();
      stop_test();
   end
   // the whole run needs well under 10k cycles
   initial begin
      repeat (40000) @(posedge mclk_i);
      n_fail++;
      stop_test();
   end
endmodule : tb_top
